/* rtl/pwm_steer_defines.svh */
// Overview of operation
// R1: Successive pulses go to the two outputs in turn, so each output is idle every other cycle.
// R2: Each output runs at half the oscillator rate with duty from zero to strictly below one half.
// R3: Both outputs are held low while the internal clock pulse is high.
// R4: On the falling edge of the clock pulse the output chosen for this cycle is driven high.
// R5: The pulse ends on the first trip of the PWM, current-limit or overcurrent comparator.
// R6: Normally the PWM comparator trip, ramp crossing the error amp level, ends the pulse.
// R7: The PWM comparator is ignored for a blanking interval after each pulse starts.
// R8: The blanking interval is nominally 375 ns and lies within 300 to 450 ns; the code blanks for 3 clock cycles, 300 ns.
// R9: Blanking also masks the current-limit comparator, which ends the pulse once blanking expires.
// R10: The overcurrent comparator is never blanked; a trip sets the fault latch and forces outputs low at once.
// R11: The fault latch clears only after soft start is fully discharged and overcurrent is gone, then soft start reruns.
// R12: A fault during soft start stops outputs at once, but discharge waits until soft start is fully charged.
// R13: While a supply is below lockout both outputs stay low and nothing operates.
// R14: A terminated pulse stays low until the next clock pulse falling edge.
// R15: The output selection flag toggles once per clock pulse and starts from a defined output after lockout.
`ifndef PWM_STEER_DEFINES_SVH
`define PWM_STEER_DEFINES_SVH
`define CLK_PERIOD_NS 100
`define BLANK_TIME_NS 375
`define BLANK_MIN_NS 300
`define BLANK_MAX_NS 450
`define BLANK_CYCLES ((`BLANK_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BLANK_CNT_W 3
`define SEL_RESET 1'b0
`endif

/* rtl/pwm_steer_pkg.sv */
`default_nettype none
package pwm_steer_pkg;
    typedef enum logic [3:0] {
        SS_DISCHARGED = 4'b0001,
        SS_CHARGING   = 4'b0010,
        SS_RUNNING    = 4'b0100,
        SS_DRAINING   = 4'b1000
    } soft_state_e;
endpackage
`default_nettype wire

/* rtl/pwm_sync2.sv */
`default_nettype none
module pwm_sync2 (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic din,
    output var  logic dout
);
    logic stage1;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stage1 <= 1'b0;
            dout   <= 1'b0;
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule
`default_nettype wire

/* rtl/alternating_pwm_output_steering.sv */
`include "pwm_steer_defines.svh"
`default_nettype none
module alternating_pwm_output_steering (
    input  wire logic                    ref_clk,
    input  wire logic                    rst,
    input  wire logic                    clockPulse,
    input  wire logic                    pwmTrip,
    input  wire logic                    currentLimitTrip,
    input  wire logic                    overcurrentTrip,
    input  wire logic                    softStartFull,
    input  wire logic                    softStartEmpty,
    output logic                         outA,
    output logic                         outB,
    output logic                         softStartDischarge,
    output logic                         faultLatched,
    output logic                         leadingEdgeMask,
    output pwm_steer_pkg::soft_state_e   softState
);
    import pwm_steer_pkg::*;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    localparam int NIN = 6;
    wire  [NIN-1:0] rawIn = {softStartEmpty, softStartFull, overcurrentTrip,
                             currentLimitTrip, pwmTrip, clockPulse};
    logic [NIN-1:0] syncIn;

    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_sync
            pwm_sync2 u_sync (
                .ref_clk (ref_clk),
                .rst     (rst),
                .din     (rawIn[gi]),
                .dout    (syncIn[gi])
            );
        end
    endgenerate

    wire clkS   = syncIn[0];
    wire pwmS   = syncIn[1];
    wire ilimS  = syncIn[2];
    wire ocS    = syncIn[3];
    wire fullS  = syncIn[4];
    wire emptyS = syncIn[5];

    // ----------------------------------------
    // clock pulse edge detection
    // ----------------------------------------
    logic clkPrev;
    wire  clkFall = clkPrev & ~clkS;
    wire  clkRise = ~clkPrev & clkS;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            clkPrev <= 1'b0;
        end else begin
            clkPrev <= clkS;
        end
    end

    // ----------------------------------------
    // soft start and fault latch
    // ----------------------------------------
    logic        fault;
    soft_state_e ssState;
    soft_state_e next_ssState;

    wire faultSet   = ocS;                                   // [R10]
    wire faultClear = (ssState == SS_DRAINING) & emptyS & ~ocS; // [R11]
    wire next_fault = faultSet | (fault & ~faultClear);

    always_comb begin
        next_ssState = ssState;
        unique case (ssState)
            SS_DISCHARGED: begin
                next_ssState = SS_CHARGING;
            end
            SS_CHARGING: begin
                if (fullS) begin
                    next_ssState = fault ? SS_DRAINING : SS_RUNNING;  // [R12]
                end
            end
            SS_RUNNING: begin
                if (fault) begin
                    next_ssState = SS_DRAINING;
                end
            end
            SS_DRAINING: begin
                if (faultClear) begin
                    next_ssState = SS_CHARGING;                      // [R11]
                end
            end
            default: begin
                next_ssState = SS_DISCHARGED;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fault   <= 1'b0;                                          // [R13]
            ssState <= SS_DISCHARGED;
        end else begin
            fault   <= next_fault;
            ssState <= next_ssState;
        end
    end

    // ----------------------------------------
    // steering flag
    // ----------------------------------------
    logic sel;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sel <= `SEL_RESET;                                        // [R15]
        end else if (clkRise) begin
            sel <= ~sel;                                              // [R1] [R15]
        end
    end

    // ----------------------------------------
    // blanking timer
    // ----------------------------------------
    localparam logic [`BLANK_CNT_W-1:0] BLANK_LOAD = `BLANK_CNT_W'(`BLANK_CYCLES);
    logic [`BLANK_CNT_W-1:0] blankCnt;
    wire  blanking = (blankCnt != '0);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            blankCnt <= '0;
        end else if (clkFall) begin
            blankCnt <= BLANK_LOAD;                                   // [R7] [R8]
        end else if (blanking) begin
            blankCnt <= blankCnt - 1'b1;
        end
    end

    // ----------------------------------------
    // pulse control
    // ----------------------------------------
    logic pulseOn;
    wire  pulseStart = clkFall & ~fault & ~faultSet;                  // [R4]
    wire  maskedTrip = ~blanking & (pwmS | ilimS);                    // [R6] [R7] [R9]
    wire  pulseEnd   = clkS | faultSet | fault | maskedTrip;          // [R3] [R5] [R10]
    wire  next_pulse = pulseStart | (pulseOn & ~pulseEnd);            // [R14]
    wire  next_outA  = next_pulse & ~sel;                             // [R1] [R2]
    wire  next_outB  = next_pulse & sel;                              // [R1] [R2]

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pulseOn <= 1'b0;
            outA    <= 1'b0;                                          // [R13]
            outB    <= 1'b0;
        end else begin
            pulseOn <= next_pulse;
            outA    <= next_outA;
            outB    <= next_outB;
        end
    end

    // ----------------------------------------
    // status outputs
    // ----------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            softStartDischarge <= 1'b1;
            faultLatched       <= 1'b0;
            leadingEdgeMask    <= 1'b0;
            softState          <= SS_DISCHARGED;
        end else begin
            softStartDischarge <= (next_ssState == SS_DRAINING);      // [R12]
            faultLatched       <= next_fault;
            leadingEdgeMask    <= clkFall | (blankCnt > `BLANK_CNT_W'(1));
            softState          <= next_ssState;
        end
    end
endmodule
`default_nettype wire

/* bench/pwm_steer_asserts.sv */
`default_nettype none
module pwm_steer_asserts (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clockPulse,
    input wire logic pwmTrip,
    input wire logic currentLimitTrip,
    input wire logic overcurrentTrip,
    input wire logic softStartFull,
    input wire logic softStartEmpty,
    input wire logic outA,
    input wire logic outB,
    input wire logic softStartDischarge,
    input wire logic faultLatched,
    input wire logic leadingEdgeMask,
    input wire pwm_steer_pkg::soft_state_e softState
);
    timeunit 1ns;
    timeprecision 100ps;
    import pwm_steer_pkg::*;
    // ----
    // checks
    // ----
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence pulseStart; $rose(outA || outB); endsequence
    sequence pulseEndA; $fell(outA); endsequence
    both_off_a: assert property (!(outA && outB)) else $error("both outputs high");
    blank_low_a: assert property (clockPulse[*4] |-> !outA && !outB) else $error("output during clock");
    fault_low_a: assert property (faultLatched && $past(faultLatched) |-> !outA && !outB)
        else $error("output during fault");
    oc_latch_a: assert property (overcurrentTrip[*2] |-> ##[1:3] faultLatched) else $error("no fault");
    mask_start_a: assert property (pulseStart |-> leadingEdgeMask) else $error("no mask");
    mask_span_a: assert property ($rose(leadingEdgeMask) |-> leadingEdgeMask[*3] ##[1:2] !leadingEdgeMask)
        else $error("mask length");
    hold_low_a: assert property (pulseEndA |-> !outA[*8]) else $error("output restarted");
    fault_clear_a: assert property ($fell(faultLatched) |-> softState == SS_CHARGING)
        else $error("no restart");
endmodule
bind alternating_pwm_output_steering pwm_steer_asserts pwm_steer_asserts_inst (.ref_clk, .rst, .clockPulse,
    .pwmTrip, .currentLimitTrip, .overcurrentTrip, .softStartFull, .softStartEmpty, .outA, .outB,
    .softStartDischarge, .faultLatched, .leadingEdgeMask, .softState);
`default_nettype wire

/* bench/pwm_power_stage.sv */
`default_nettype none
module pwm_power_stage (
    input wire logic       ref_clk,
    input wire logic       outA,
    input wire logic       outB,
    input wire logic       softStartDischarge,
    input wire logic       ocCmd,
    input wire logic [4:0] pwmAt,
    input wire logic [4:0] ilimAt,
    output logic           pwmTrip,
    output logic           currentLimitTrip,
    output logic           overcurrentTrip,
    output logic           softStartFull,
    output logic           softStartEmpty
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----
    // ramp and soft start
    // ----
    logic [4:0] onCnt = 5'h00;
    logic [3:0] ssLevel = 4'h0;
    always_ff @(posedge ref_clk) begin
        onCnt <= (outA || outB) ? onCnt + 5'h01 : 5'h00;
        if (softStartDischarge && ssLevel != 4'h0) ssLevel <= ssLevel - 4'h1;
        else if (!softStartDischarge && ssLevel != 4'hF) ssLevel <= ssLevel + 4'h1;
    end
    assign pwmTrip = (outA || outB) && onCnt >= pwmAt;
    assign currentLimitTrip = (outA || outB) && onCnt >= ilimAt;
    assign overcurrentTrip = ocCmd;
    assign softStartFull = ssLevel == 4'hF;
    assign softStartEmpty = ssLevel == 4'h0;
endmodule
`default_nettype wire

/* bench/tb.sv */
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import pwm_steer_pkg::*;
    typedef struct { logic [4:0] p; logic [4:0] l; int lo; int hi; } row_s;
    logic        ref_clk, rst, clockPulse, ocCmd, outA, outB, ssDis, faultLatched, mask, lastA, a;
    logic [4:0]  pwmAt, ilimAt;
    wire logic   pwmTrip, ilimTrip, ocTrip, ssFull, ssEmpty;
    soft_state_e softState;
    int          mismatches, num_checks, w, i;
    row_s        rows[5] = '{'{5'h06, 5'h1F, 7, 11}, '{5'h1F, 5'h05, 6, 10}, '{5'h00, 5'h1F, 4, 8},
                             '{5'h1F, 5'h01, 4, 8}, '{5'h1F, 5'h1F, 15, 20}};
    alternating_pwm_output_steering alternating_pwm_output_steering_inst (.ref_clk, .rst, .clockPulse, .pwmTrip,
        .currentLimitTrip(ilimTrip), .overcurrentTrip(ocTrip), .softStartFull(ssFull), .softStartEmpty(ssEmpty),
        .outA, .outB, .softStartDischarge(ssDis), .faultLatched, .leadingEdgeMask(mask), .softState);
    pwm_power_stage pwm_power_stage_inst (.ref_clk, .outA, .outB, .softStartDischarge(ssDis), .ocCmd, .pwmAt,
        .ilimAt, .pwmTrip, .currentLimitTrip(ilimTrip), .overcurrentTrip(ocTrip), .softStartFull(ssFull),
        .softStartEmpty(ssEmpty));
    // ----
    // stimulus
    // ----
    task automatic step; @(posedge ref_clk); #10; endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic to_high;
        for (i = 0; i < 100 && !(outA || outB); i++) step;
        if (i == 100) begin mismatches++; give_verdict; end
    endtask
    task automatic wait_pulse(output int wd, output logic isA);
        to_high;
        isA = outA;
        for (wd = 0; wd < 100 && (outA || outB); wd++) step;
        if (wd == 100) begin mismatches++; give_verdict; end
    endtask
    initial begin ref_clk = 0; forever #50 ref_clk = ~ref_clk; end
    initial begin
        clockPulse = 1;
        forever begin repeat (4) step; clockPulse = 0; repeat (18) step; clockPulse = 1; end
    end
    initial begin
        {rst, ocCmd, pwmAt, ilimAt, mismatches, num_checks} = {2'b10, 10'h3FF, 64'h0};
        repeat (4) step;
        `CHK("outs", 2'b00, {outA, outB})
        `CHK("ssDis", 1'b1, ssDis)
        `CHK("state", SS_DISCHARGED, softState)
        rst = 0;
        wait_pulse(w, lastA);
        `CHK("firstA", 1'b0, lastA)
        foreach (rows[k]) begin
            {pwmAt, ilimAt} = {rows[k].p, rows[k].l};
            wait_pulse(w, a);
            `CHK("width", 1'b1, w >= rows[k].lo && w <= rows[k].hi)
            `CHK("alternate", ~lastA, a)
            lastA = a;
        end
        to_high;
        `CHK("mask", 1'b1, mask)
        repeat (5) step;
        ocCmd = 1;
        repeat (5) step;
        `CHK("fault", 3'b100, {faultLatched, outA, outB})
        `CHK("drain", {1'b1, SS_DRAINING}, {ssDis, softState})
        ocCmd = 0;
        for (i = 0; i < 300 && faultLatched; i++) step;
        `CHK("cleared", 1'b0, faultLatched)
        ocCmd = 1;
        repeat (4) step;
        `CHK("ssfault", {1'b1, 1'b0, SS_CHARGING}, {faultLatched, ssDis, softState})
        ocCmd = 0;
        for (i = 0; i < 300 && faultLatched; i++) step;
        `CHK("cleared2", 1'b0, faultLatched)
        wait_pulse(w, a);
        `CHK("restart", 1'b1, w > 0)
        give_verdict;
    end
endmodule
`default_nettype wire
